// ### hw/vic_pkg.sv
package vic_pkg;

	// ****************************************
	// register map, 32-bit aligned words
	// ****************************************
	localparam logic [7:0] OFS_EN_MAIN   = 8'h00;
	localparam logic [7:0] OFS_EN_SECOND = 8'h04;
	localparam logic [7:0] OFS_LV_MAIN   = 8'h08;
	localparam logic [7:0] OFS_LV_SECOND = 8'h0C;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] RST_REG       = 8'h00;

	// writable bits: bit 6 of the main enable, bits 7:6 of the main level are reserved
	localparam logic [7:0] MASK_EN_MAIN  = 8'hBF;
	localparam logic [7:0] MASK_MAIN     = 8'h3F;
	localparam logic [7:0] MASK_SECOND   = 8'h13;
	localparam int         GATE_BIT      = 7;

	// ****************************************
	// request slots in polling order, slot 0 first
	// ****************************************
	localparam int         NSLOT         = 10;
	localparam int         SLOT_EXT0     = 0;
	localparam int         SLOT_EXT1     = 4;
	localparam int         SLOT_TIMER0   = 2;
	localparam int         SLOT_TIMER1   = 6;
	// slot 5 is reserved and never requests
	localparam logic [9:0] SLOT_USED     = 10'h3DF;
	// slots whose enable and level live in the secondary registers
	localparam logic [9:0] SLOT_SECOND   = 10'h08A;
	// bit position of each slot inside its register, slot 0 lowest
	localparam logic [9:0][2:0] SLOT_BIT = {3'h5, 3'h4, 3'h0, 3'h3, 3'h0,
	                                        3'h2, 3'h1, 3'h1, 3'h4, 3'h0};
	// fixed call targets
	localparam logic [9:0][15:0] SLOT_VEC = {16'h002B, 16'h0023, 16'h0033, 16'h001B,
	                                         16'h0000, 16'h0013, 16'h0043, 16'h000B,
	                                         16'h004B, 16'h0003};

	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_ACK  = 2'b10
	} vic_apb_t;

endpackage : vic_pkg

// ### hw/vic_ctrl.sv
`timescale 1ns/100ps
// What this block does
// - per-source level bit, one means high
// - high request preempts a running low routine
// - running high routine blocks every request
// - high level wins over low in poll
// - fixed polling order within one level
// - per-source enable bit gates that source
// - global gate zero blocks all acknowledges
// - main enable bit layout
// - secondary enable bit layout
// - main level bit layout
// - secondary level bit layout
// - sample flags once, poll next machine cycle
// - no call while equal/higher level runs
// - call only on instruction's last cycle
// - exit instruction or register access blocks
// - every poll uses only fresh samples
// - call pushes program counter, not status word
// - call loads the slot's fixed vector
// - exit instruction clears in-progress, resumes program
// - plain return leaves in-progress set
// - external flag cleared on call if edge mode
// - timer 0/1 flags cleared on call
module vic_ctrl (
	input  wire logic        ref_clk,        // core clock, 125 MHz
	input  wire logic        rst_n,          // async reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb access phase
	input  wire logic        pwrite,         // apb direction
	input  wire logic [7:0]  paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error on unmapped address
	input  wire logic [9:0]  irq_flags,      // request flags, slot order
	input  wire logic        ext0_edge_mode, // external line 0 is edge triggered
	input  wire logic        ext1_edge_mode, // external line 1 is edge triggered
	input  wire logic        sample_phase,   // one pulse per machine cycle
	input  wire logic        last_cycle,     // final cycle of current instruction
	input  wire logic        instr_exit,     // irq_exit_instr is executing
	input  wire logic        instr_irq_reg,  // instruction touches enable/level regs
	output logic             hw_long_call,   // pulse: push pc and jump
	output logic      [15:0] call_vector,    // jump target of the call
	output logic      [3:0]  call_slot,      // slot being served
	output logic             call_level,     // level of the served slot
	output logic      [9:0]  flag_clear,     // pulse: clear these request flags
	output logic             in_prog_hi,     // high routine in progress
	output logic             in_prog_lo      // low routine in progress
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		vic_pkg::vic_apb_t apb;
		logic [31:0]       rdata;
		logic              ready;
		logic              err;
		logic [7:0]        en_main;
		logic [7:0]        en_second;
		logic [7:0]        lv_main;
		logic [7:0]        lv_second;
		logic [9:0]        sampled;
		logic              in_hi;
		logic              in_lo;
		logic              call;
		logic [15:0]       vec;
		logic [3:0]        slot;
		logic              level;
		logic [9:0]        clr;
	} vic_state_t;

	vic_state_t s_r;
	vic_state_t s_nxt;

	logic [9:0] slot_en;
	logic [9:0] slot_lv;
	logic [9:0] req;
	logic       reg_hit;
	logic       wr_now;

	// ****************************************
	// per-slot enable and level lookup
	// ****************************************
	// each slot picks its bit from the main or the secondary register
	for (genvar i = 0; i < vic_pkg::NSLOT; i++) begin : g_slot
		assign slot_en[i] = vic_pkg::SLOT_USED[i] &
			(vic_pkg::SLOT_SECOND[i] ? s_r.en_second[vic_pkg::SLOT_BIT[i]]
			                         : s_r.en_main[vic_pkg::SLOT_BIT[i]]);
		assign slot_lv[i] = vic_pkg::SLOT_SECOND[i] ?
			s_r.lv_second[vic_pkg::SLOT_BIT[i]] :
			s_r.lv_main[vic_pkg::SLOT_BIT[i]];
	end

	// only the sample taken at the previous phase counts
	assign req     = s_r.sampled & slot_en & {10{s_r.en_main[vic_pkg::GATE_BIT]}};
	assign reg_hit = (paddr == vic_pkg::OFS_EN_MAIN) || (paddr == vic_pkg::OFS_EN_SECOND) ||
	                 (paddr == vic_pkg::OFS_LV_MAIN) || (paddr == vic_pkg::OFS_LV_SECOND) ||
	                 (paddr == vic_pkg::OFS_STATUS);
	assign wr_now  = psel && penable && s_r.ready && pwrite && reg_hit;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic       found;
		logic       pick_hi;
		logic [3:0] pick;
		logic       blocked;
		found   = 1'b0;
		pick_hi = 1'b0;
		pick    = 4'h0;
		blocked = 1'b0;
		s_nxt       = s_r;
		s_nxt.call  = 1'b0;
		s_nxt.clr   = '0;
		s_nxt.ready = 1'b0;
		s_nxt.err   = 1'b0;

		// apb slave: one wait-free access cycle after setup
		unique case (s_r.apb)
			vic_pkg::APB_IDLE: begin
				if (psel && !penable) begin
					s_nxt.apb   = vic_pkg::APB_ACK;
					s_nxt.ready = 1'b1;
					s_nxt.err   = !((paddr == vic_pkg::OFS_EN_MAIN) ||
					                (paddr == vic_pkg::OFS_EN_SECOND) ||
					                (paddr == vic_pkg::OFS_LV_MAIN) ||
					                (paddr == vic_pkg::OFS_LV_SECOND) ||
					                (paddr == vic_pkg::OFS_STATUS));
					unique case (paddr)
						vic_pkg::OFS_EN_MAIN:   s_nxt.rdata = {24'h0, s_r.en_main};
						vic_pkg::OFS_EN_SECOND: s_nxt.rdata = {24'h0, s_r.en_second};
						vic_pkg::OFS_LV_MAIN:   s_nxt.rdata = {24'h0, s_r.lv_main};
						vic_pkg::OFS_LV_SECOND: s_nxt.rdata = {24'h0, s_r.lv_second};
						vic_pkg::OFS_STATUS:    s_nxt.rdata = {26'h0, s_r.in_hi, s_r.in_lo,
						                                       s_r.slot};
						default:                s_nxt.rdata = 32'h0;
					endcase
				end
			end
			vic_pkg::APB_ACK: begin
				s_nxt.apb = vic_pkg::APB_IDLE;
				if (wr_now) begin
					unique case (paddr)
						vic_pkg::OFS_EN_MAIN:   s_nxt.en_main   = pwdata[7:0] & vic_pkg::MASK_EN_MAIN;
						vic_pkg::OFS_EN_SECOND: s_nxt.en_second = pwdata[7:0] & vic_pkg::MASK_SECOND;
						vic_pkg::OFS_LV_MAIN:   s_nxt.lv_main   = pwdata[7:0] & vic_pkg::MASK_MAIN;
						vic_pkg::OFS_LV_SECOND: s_nxt.lv_second = pwdata[7:0] & vic_pkg::MASK_SECOND;
						default:                s_nxt.en_main   = s_r.en_main;
					endcase
				end
			end
		endcase

		// pick: highest-level requester first, then lowest slot number
		for (int i = vic_pkg::NSLOT - 1; i >= 0; i--) begin
			if (req[i] && slot_lv[i]) begin
				pick    = 4'(i);
				pick_hi = 1'b1;
				found   = 1'b1;
			end
		end
		if (!found) begin
			for (int i = vic_pkg::NSLOT - 1; i >= 0; i--) begin
				if (req[i]) begin
					pick  = 4'(i);
					found = 1'b1;
				end
			end
		end

		// a running high routine blocks all; a running low one blocks low only
		blocked = s_r.in_hi || (s_r.in_lo && !pick_hi) ||
		          !last_cycle ||
		          instr_exit || instr_irq_reg;

		if (sample_phase) begin
			// exit instruction ends the innermost routine; a plain return is not seen here
			if (instr_exit && last_cycle) begin
				if (s_r.in_hi) begin
					s_nxt.in_hi = 1'b0;
				end else begin
					s_nxt.in_lo = 1'b0;
				end
			end
			if (found && !blocked) begin
				s_nxt.call  = 1'b1;
				s_nxt.vec   = vic_pkg::SLOT_VEC[pick];
				s_nxt.slot  = pick;
				s_nxt.level = pick_hi;
				if (pick_hi) begin
					s_nxt.in_hi = 1'b1;
				end else begin
					s_nxt.in_lo = 1'b1;
				end
				// only edge-mode lines and timers 0/1 lose their flag here
				s_nxt.clr[pick] = (pick == 4'(vic_pkg::SLOT_EXT0)   && ext0_edge_mode) ||
				                  (pick == 4'(vic_pkg::SLOT_EXT1)   && ext1_edge_mode) ||
				                  (pick == 4'(vic_pkg::SLOT_TIMER0)) ||
				                  (pick == 4'(vic_pkg::SLOT_TIMER1));
			end
			// fresh capture every machine cycle; nothing blocked is remembered
			s_nxt.sampled = irq_flags & vic_pkg::SLOT_USED;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r           <= '0;
			s_r.apb       <= vic_pkg::APB_IDLE;
			s_r.en_main   <= vic_pkg::RST_REG;
			s_r.en_second <= vic_pkg::RST_REG;
			s_r.lv_main   <= vic_pkg::RST_REG;
			s_r.lv_second <= vic_pkg::RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs are the state flip-flops themselves
	assign prdata       = s_r.rdata;
	assign pready       = s_r.ready;
	assign pslverr      = s_r.err;
	assign hw_long_call = s_r.call;
	assign call_vector  = s_r.vec;
	assign call_slot    = s_r.slot;
	assign call_level   = s_r.level;
	assign flag_clear   = s_r.clr;
	assign in_prog_hi   = s_r.in_hi;
	assign in_prog_lo   = s_r.in_lo;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_vector_table: assert property (hw_long_call |->
		call_vector == vic_pkg::SLOT_VEC[call_slot]) else $error("wrong call vector");
	chk_high_blocks: assert property (hw_long_call |-> !$past(in_prog_hi))
		else $error("call while high routine runs");
	chk_low_nest: assert property (hw_long_call && !call_level |-> !$past(in_prog_lo))
		else $error("low call while low routine runs");
	chk_global_gate: assert property (hw_long_call |-> $past(s_r.en_main[vic_pkg::GATE_BIT]))
		else $error("call with global gate off");
	chk_last_cycle: assert property (hw_long_call |-> $past(last_cycle && sample_phase))
		else $error("call outside last cycle");
	chk_exit_block: assert property (hw_long_call |-> !$past(instr_exit || instr_irq_reg))
		else $error("call during blocking instruction");
	chk_level_mark: assert property (hw_long_call |-> (call_level ? in_prog_hi : in_prog_lo))
		else $error("in-progress not set");
	chk_timer_clear: assert property (hw_long_call && call_slot == 4'(vic_pkg::SLOT_TIMER0)
		|-> flag_clear[vic_pkg::SLOT_TIMER0]) else $error("timer0 flag not cleared");
	chk_apb_answer: assert property (psel && !penable && s_r.apb == vic_pkg::APB_IDLE
		|=> pready ##1 !pready) else $error("apb answer not one cycle");

	// ****************************************
	// per-rule checks on calls, flags and registers
	// ****************************************
	// a flag is only ever cleared together with the call that served it
	chk_clear_call: assert property (
		|flag_clear
		|-> hw_long_call)
		else $error("flag clear without call");
	// one call serves one slot, so at most one flag may drop
	chk_clear_single: assert property (
		hw_long_call
		|-> $onehot0(flag_clear))
		else $error("more than one flag cleared");
	// software-cleared sources must keep their flag through the call
	chk_soft_clear: assert property (
		hw_long_call && call_slot != 4'(vic_pkg::SLOT_EXT0) && call_slot != 4'(vic_pkg::SLOT_EXT1) &&
		call_slot != 4'(vic_pkg::SLOT_TIMER0) && call_slot != 4'(vic_pkg::SLOT_TIMER1) |-> !(|flag_clear))
		else $error("software flag cleared by hardware");
	// timer 1 overflow drops on service like timer 0
	chk_timer1_clear: assert property (
		hw_long_call && call_slot == 4'(vic_pkg::SLOT_TIMER1)
		|-> flag_clear[vic_pkg::SLOT_TIMER1])
		else $error("timer1 flag not cleared");
	// a level-mode line keeps its flag: the source itself must let go
	chk_ext0_mode: assert property (
		hw_long_call && call_slot == 4'(vic_pkg::SLOT_EXT0)
		|-> flag_clear[vic_pkg::SLOT_EXT0] == $past(ext0_edge_mode))
		else $error("ext line 0 clear does not follow mode");
	// same for the second external line
	chk_ext1_mode: assert property (
		hw_long_call && call_slot == 4'(vic_pkg::SLOT_EXT1)
		|-> flag_clear[vic_pkg::SLOT_EXT1] == $past(ext1_edge_mode))
		else $error("ext line 1 clear does not follow mode");
	// the reserved slot has no vector and must never be served
	chk_used_slot: assert property (
		hw_long_call
		|-> vic_pkg::SLOT_USED[call_slot])
		else $error("call to unused slot");
	// a disabled source is invisible to the poll
	chk_slot_enabled: assert property (
		hw_long_call
		|-> |($past(slot_en) & (10'h001 << call_slot)))
		else $error("call to disabled slot");
	// the served slot must have been set in the previous capture
	chk_fresh_sample: assert property (
		hw_long_call
		|-> |($past(s_r.sampled) & (10'h001 << call_slot)))
		else $error("call without fresh sample");
	// the reported level is the slot's own level bit
	chk_level_bit: assert property (
		hw_long_call
		|-> call_level == |($past(slot_lv) & (10'h001 << call_slot)))
		else $error("call level differs from level bit");
	// a low call is only legal when no high request was pending
	chk_high_first: assert property (
		hw_long_call && !call_level
		|-> $past(req & slot_lv) == 10'h000)
		else $error("low served over pending high");
	// no lower-numbered slot of the same level may have been waiting
	chk_poll_order: assert property (
		hw_long_call |-> ((call_level ? $past(req & slot_lv) : $past(req & ~slot_lv)) &
		((10'h001 << call_slot) - 10'h001)) == 10'h000)
		else $error("polling order broken");
	// exit drops the high mark first when it is set
	chk_exit_high: assert property (
		sample_phase && last_cycle && instr_exit && in_prog_hi
		|=> !in_prog_hi)
		else $error("exit did not end high routine");
	// with no high routine, exit ends the low one
	chk_exit_low: assert property (
		sample_phase && last_cycle && instr_exit && !in_prog_hi && in_prog_lo
		|=> !in_prog_lo)
		else $error("exit did not end low routine");
	// only an exit may end a high routine; a plain return leaves it set
	chk_high_holds: assert property (
		in_prog_hi && !(sample_phase && last_cycle && instr_exit)
		|=> in_prog_hi)
		else $error("high in-progress lost without exit");
	// the low mark survives everything but its own exit
	chk_low_holds: assert property (
		in_prog_lo && !(sample_phase && last_cycle && instr_exit && !in_prog_hi)
		|=> in_prog_lo)
		else $error("low in-progress lost without exit");
	// the high mark rises only with a high call
	chk_high_set: assert property (
		$rose(in_prog_hi)
		|-> hw_long_call && call_level)
		else $error("high in-progress set without call");
	// the low mark rises only with a low call
	chk_low_set: assert property (
		$rose(in_prog_lo)
		|-> hw_long_call && !call_level)
		else $error("low in-progress set without call");
	// register writes land masked one cycle after the access edge
	chk_wr_en_main: assert property (
		wr_now && paddr == vic_pkg::OFS_EN_MAIN
		|=> s_r.en_main == ($past(pwdata[7:0]) & vic_pkg::MASK_EN_MAIN))
		else $error("main enable write lost");
	// secondary enable keeps only its three live bits
	chk_wr_en_second: assert property (
		wr_now && paddr == vic_pkg::OFS_EN_SECOND
		|=> s_r.en_second == ($past(pwdata[7:0]) & vic_pkg::MASK_SECOND))
		else $error("secondary enable write lost");
	// main level register keeps six live bits
	chk_wr_lv_main: assert property (
		wr_now && paddr == vic_pkg::OFS_LV_MAIN
		|=> s_r.lv_main == ($past(pwdata[7:0]) & vic_pkg::MASK_MAIN))
		else $error("main level write lost");
	// secondary level register keeps three live bits
	chk_wr_lv_second: assert property (
		wr_now && paddr == vic_pkg::OFS_LV_SECOND
		|=> s_r.lv_second == ($past(pwdata[7:0]) & vic_pkg::MASK_SECOND))
		else $error("secondary level write lost");
	// reserved bits of the main enable and main level registers must stay zero whatever software writes
	chk_reserved_zero: assert property (
		(s_r.en_main & ~vic_pkg::MASK_EN_MAIN) == 8'h00
		&& (s_r.lv_main & ~vic_pkg::MASK_MAIN) == 8'h00)
		else $error("reserved bit set");

	cov_high_preempt: cover property (hw_long_call && call_level && $past(in_prog_lo));
	cov_exit_clear:   cover property (in_prog_hi ##1 !in_prog_hi);
	cov_low_call:     cover property (hw_long_call && !call_level);
	cov_unmapped:     cover property (pready && pslverr);
	cov_both_levels:  cover property (in_prog_hi && in_prog_lo);

endmodule : vic_ctrl

// ### tb/vic_seq_model.sv
`timescale 1ns/100ps
// ****************
// sequencer and request sources
// ****************
module vic_seq_model #(
	parameter int MC = 4                 // clocks per machine cycle
) (
	input  wire logic       ref_clk,      // core clock
	input  wire logic       rst_n,        // async reset, active low
	input  wire logic [9:0] set_req,      // pulse: sources raise flags
	input  wire logic [9:0] drop,         // pulse: routine clears flags
	input  wire logic [9:0] flag_clear,   // pulse: hardware clears on call
	output logic      [9:0] irq_flags,    // flags toward the controller
	output logic            sample_phase  // one pulse per machine cycle
);
	logic [2:0] cnt_r;
	// flags stay up until cleared, so a blocked request is seen again only if still set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r        <= 3'h0;
			sample_phase <= 1'b0;
			irq_flags    <= 10'h000;
		end else begin
			cnt_r        <= (cnt_r == MC - 1) ? 3'h0 : cnt_r + 3'h1;
			sample_phase <= (cnt_r == MC - 1);
			irq_flags    <= (irq_flags | set_req) & ~flag_clear & ~drop;
		end
	end
endmodule : vic_seq_model

// ### tb/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, em, es, lm, ls;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, hw_long_call, call_level, in_prog_hi, in_prog_lo, sample_phase;
	logic [9:0] irq_flags, flag_clear, set_req = 0, drop = 0, samp_q, exp_fc;
	logic x0 = 0, x1 = 0, last_cycle = 0, instr_exit = 0, instr_irq_reg = 0;
	logic [15:0] call_vector, r = 16'h0BEB;
	logic [3:0] call_slot, last_s;
	logic rh, rl, exp_c, exp_l, ok;
	int err_count = 0, check_count = 0, h, l, s, exp_s;
	localparam logic [15:0] VT [10] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
		16'h0000, 16'h001B, 16'h0033, 16'h0023, 16'h002B};
	localparam logic [7:0] MSK [4] = '{8'hBF, 8'h13, 8'h3F, 8'h13};
	always #4 ref_clk = ~ref_clk;
	vic_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_flags(irq_flags), .ext0_edge_mode(x0), .ext1_edge_mode(x1),
		.sample_phase(sample_phase), .last_cycle(last_cycle), .instr_exit(instr_exit),
		.instr_irq_reg(instr_irq_reg), .hw_long_call(hw_long_call), .call_vector(call_vector),
		.call_slot(call_slot), .call_level(call_level), .flag_clear(flag_clear),
		.in_prog_hi(in_prog_hi), .in_prog_lo(in_prog_lo));
	vic_seq_model seq (.ref_clk(ref_clk), .rst_n(rst_n), .set_req(set_req), .drop(drop),
		.flag_clear(flag_clear), .irq_flags(irq_flags), .sample_phase(sample_phase));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	// first eligible slot of one level in polling order, -1 if none
	function automatic int pick(input logic [9:0] f, input logic lvl);
		logic [9:0] en, lv;
		en = {em[5], em[4], es[0], em[3], 1'b0, em[2], es[1], em[1], es[4], em[0]};
		lv = {lm[5], lm[4], ls[0], lm[3], 1'b0, lm[2], ls[1], lm[1], ls[4], lm[0]};
		for (int i = 0; i < 10; i++)
			if (f[i] && en[i] && em[7] && lv[i] == lvl) return i;
		return -1;
	endfunction : pick
	task results;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		for (int n = 0; ; n++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
			if (n > 20) begin err_count++; results(); end
		end
		q = prdata; e = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb
	// ****************
	// reference model of the controller
	// ****************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{em, es, lm, ls} <= 32'h0; samp_q <= 0; {rh, rl, exp_c, exp_l} <= 0; last_s <= 0;
		end else begin
			exp_c <= 0;
			if (psel && penable && pready && pwrite && paddr < 8'h10)
				case (paddr[3:2])
					2'h0: em <= pwdata[7:0] & 8'hBF;
					2'h1: es <= pwdata[7:0] & 8'h13;
					2'h2: lm <= pwdata[7:0] & 8'h3F;
					default: ls <= pwdata[7:0] & 8'h13;
				endcase
			if (sample_phase) begin
				h = pick(samp_q, 1); l = pick(samp_q, 0); s = (h >= 0) ? h : l;
				ok = last_cycle && !instr_exit && !instr_irq_reg && s >= 0 && !rh && !(rl && h < 0);
				if (last_cycle && instr_exit) begin if (rh) rh <= 0; else rl <= 0; end
				if (ok) begin
					exp_c <= 1; exp_s <= s; exp_l <= h >= 0; last_s <= s[3:0];
					if (h >= 0) rh <= 1; else rl <= 1;
					exp_fc <= 10'(s == 2 || s == 6 || (s == 0 && x0) || (s == 4 && x1)) << s;
				end
				samp_q <= irq_flags;
			end
		end
	end
	always @(negedge ref_clk) if (rst_n) begin
		`CHK("in_prog_hi", rh, in_prog_hi)
		`CHK("in_prog_lo", rl, in_prog_lo)
		`CHK("call", exp_c, hw_long_call)
		if (exp_c) begin
			`CHK("slot", exp_s[3:0], call_slot)
			`CHK("vector", VT[exp_s], call_vector)
			`CHK("level", exp_l, call_level)
			`CHK("flag_clear", exp_fc, flag_clear)
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1;
		for (int i = 0; i < 6; i++) begin
			apb(0, 8'(i * 4), 0);
			`CHK("reset", 32'h0, q)
			`CHK("pslverr", i == 5, e)
		end
		for (int i = 0; i < 5; i++) apb(1, 8'(i * 4), 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++) begin
			apb(0, 8'(i * 4), 0);
			`CHK("mask", {24'h0, MSK[i]}, q)
		end
		// random traffic; the reference checks every cycle
		for (int i = 0; i < 300; i++) begin
			r = lfsr(r);
			if (r[3:1] == 0) apb(1, {4'h0, r[5:4], 2'h0}, {24'h0, r[15:8] | {r[6], 7'h0}});
			@(posedge ref_clk);
			set_req <= r[9:0]; drop <= r[13:4] & {10{r[2]}};
			last_cycle <= r[11] | r[12]; instr_exit <= r[13] & r[14] & r[0];
			instr_irq_reg <= r[15] & r[5]; x0 <= r[7]; x1 <= r[8];
			@(posedge ref_clk);
			set_req <= 0; drop <= 0;
			repeat (r[3:0]) @(posedge ref_clk);
		end
		last_cycle <= 0;
		apb(0, 8'h10, 0);
		`CHK("status", {26'h0, rh, rl, last_s}, q)
		results();
	end
endmodule : tb
